//--- dma_channel.sv
// module: one dma channel, software start or event paced
`timescale 1ns/1ps
`default_nettype none
module dma_channel
	import dma_pkg::*;
(
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// configuration from the cpu side
	input wire channel_control_s ctrl_i,
	input wire channel_setup_s setup_i,
	input wire logic setup_load_i,
	input wire logic done_clear_i,
	// peripheral events, asynchronous to sys_clk
	input wire logic conversion_done_event_i,
	input wire logic periph_a_event_i,
	input wire logic periph_b_event_i,
	// memory port, single beat per cycle with ready
	output mem_req_s mem_o,
	input wire logic mem_ready_i,
	input wire logic [DATA_W-1:0] mem_rdata_i,
	// status
	output logic busy_o,
	output logic done_o,
	output logic end_irq_o,
	output logic [CNT_W-1:0] count_o
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} state_e;

	// ==========================================================
	// event synchronisers
	logic [2:0] ev_meta_r;
	logic [2:0] ev_sync_r;
	logic [2:0] ev_prev_r;
	wire [2:0] ev_raw = {periph_b_event_i, periph_a_event_i, conversion_done_event_i};
	wire [2:0] ev_rise = ev_sync_r & ~ev_prev_r;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ev_meta_r <= 3'h0;
			ev_sync_r <= 3'h0;
			ev_prev_r <= 3'h0;
		end else if (clk_en_i) begin
			ev_meta_r <= ev_raw;
			ev_sync_r <= ev_meta_r;
			ev_prev_r <= ev_sync_r;
		end
	end

	// ==========================================================
	// working registers
	state_e state_r;
	state_e state_nxt;
	logic [ADDR_W-1:0] src_r;
	logic [ADDR_W-1:0] dst_r;
	logic [CNT_W-1:0] cnt_r;
	logic [DATA_W-1:0] data_r;
	logic pend_r;
	logic armed_r;
	logic done_r;
	logic irq_r;

	// ==========================================================
	// trigger decode
	// the software code maps to no event, so a stray pin edge cannot start a software block
	function automatic logic sel_event(input logic [TRIG_W-1:0] sel, input logic [2:0] rise);
		unique case (sel)
			TRIG_SOFTWARE: sel_event = 1'b0;
			TRIG_CONV_DONE: sel_event = rise[0];
			TRIG_PERIPH_A: sel_event = rise[1];
			TRIG_PERIPH_B: sel_event = rise[2];
		endcase
	endfunction : sel_event

	// ==========================================================
	// request decode
	// a halted channel only accepts new setup; loading while running is ignored
	wire load_ok = setup_load_i && !ctrl_i.enable;
	wire sw_only = (ctrl_i.trigger_sel == TRIG_SOFTWARE);
	wire sw_go = ctrl_i.enable && ctrl_i.software_start_bit && !armed_r;

	// one synchronised edge per event is one transfer request
	wire ev_hit = sel_event(ctrl_i.trigger_sel, ev_rise);
	wire hw_req = ctrl_i.enable && !sw_only && ev_hit && !done_r;

	wire beat_go = (state_r == ST_IDLE) && (sw_only ? armed_r : pend_r);
	wire rd_done = (state_r == ST_READ) && mem_ready_i;
	wire wr_done = (state_r == ST_WRITE) && mem_ready_i;
	// count holds transfers minus one; the block ends when it would wrap below zero
	wire last_beat = wr_done && (cnt_r == CNT_RESET);
	wire [CNT_W-1:0] cnt_dec = cnt_r - CNT_ONE;

	wire [ADDR_W-1:0] src_next = (ctrl_i.src_mode == ADDR_INCR) ? src_r + ADDR_STEP : src_r;
	wire [ADDR_W-1:0] dst_next = (ctrl_i.dst_mode == ADDR_INCR) ? dst_r + ADDR_STEP : dst_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (beat_go) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				if (mem_ready_i) begin
					state_nxt = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (mem_ready_i) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// state and datapath
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ST_IDLE;
		end else if (clk_en_i) begin
			state_r <= ctrl_i.enable ? state_nxt : ST_IDLE;
		end
	end

	// same path serves internal and external memory; only addresses differ
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			src_r <= ADDR_RESET;
			dst_r <= ADDR_RESET;
			cnt_r <= CNT_RESET;
		end else if (clk_en_i) begin
			if (load_ok) begin
				src_r <= setup_i.src_addr;
				dst_r <= setup_i.dst_addr;
				cnt_r <= setup_i.transfer_count_reg;
			end else if (wr_done) begin
				src_r <= src_next;
				dst_r <= dst_next;
				cnt_r <= cnt_dec;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_r <= {DATA_W{1'b0}};
		end else if (clk_en_i && rd_done) begin
			data_r <= mem_rdata_i;
		end
	end

	// pending request: a new event wins over the consume of the previous one
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pend_r <= 1'b0;
		end else if (clk_en_i) begin
			if (!ctrl_i.enable) begin
				pend_r <= 1'b0;
			end else if (hw_req) begin
				pend_r <= 1'b1;
			end else if (beat_go) begin
				pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			armed_r <= 1'b0;
		end else if (clk_en_i) begin
			if (!ctrl_i.enable || last_beat) begin
				armed_r <= 1'b0;
			end else if (sw_go) begin
				armed_r <= 1'b1;
			end
		end
	end

	// done is sticky; a block end in the clear cycle still sets it
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_r <= 1'b0;
			irq_r <= 1'b0;
		end else if (clk_en_i) begin
			irq_r <= last_beat;
			if (last_beat) begin
				done_r <= 1'b1;
			end else if (done_clear_i || load_ok) begin
				done_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// outputs
	// wdata stands from the read capture until the write beat is accepted
	always_comb begin
		mem_o.req = (state_r != ST_IDLE);
		mem_o.we = (state_r == ST_WRITE);
		mem_o.addr = (state_r == ST_WRITE) ? dst_r : src_r;
		mem_o.wdata = data_r;
	end

	assign busy_o = (state_r != ST_IDLE) || armed_r || pend_r;
	assign done_o = done_r;
	assign end_irq_o = irq_r;
	assign count_o = cnt_r;
endmodule : dma_channel
`default_nettype wire

//--- dma_pkg.sv
// package: constants and types for one dma channel with software and event start
package dma_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 16;
	localparam int CNT_W = 16;
	localparam int TRIG_W = 2;
	localparam logic [TRIG_W-1:0] TRIG_SOFTWARE = 2'h0;
	localparam logic [TRIG_W-1:0] TRIG_CONV_DONE = 2'h1;
	localparam logic [TRIG_W-1:0] TRIG_PERIPH_A = 2'h2;
	localparam logic [TRIG_W-1:0] TRIG_PERIPH_B = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0001;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;

	typedef enum logic [0:0] {
		ADDR_FIXED = 1'b0,
		ADDR_INCR = 1'b1
	} addr_mode_e;

	// channel_control_reg and its companions, as presented by software
	typedef struct packed {
		logic enable;
		logic software_start_bit;
		logic [TRIG_W-1:0] trigger_sel;
		addr_mode_e src_mode;
		addr_mode_e dst_mode;
	} channel_control_s;

	typedef struct packed {
		logic [ADDR_W-1:0] src_addr;
		logic [ADDR_W-1:0] dst_addr;
		logic [CNT_W-1:0] transfer_count_reg;
	} channel_setup_s;

	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
		logic we;
		logic [DATA_W-1:0] wdata;
	} mem_req_s;
endpackage : dma_pkg

//--- mem_model.sv
// partner: word memory answering the channel's beats
`timescale 1ns/1ps
`default_nettype none
module mem_model
	import dma_pkg::*;
(
	// clock and pacing
	input wire logic sys_clk_i,
	input wire logic slow_i,
	// channel beats
	input wire mem_req_s mem_i,
	output logic mem_ready_o,
	output logic [DATA_W-1:0] mem_rdata_o
);
	// ====
	// storage
	logic [DATA_W-1:0] mem [256];
	logic tog_r = 1'b0;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'hA500 | 16'(i);
	// slow mode holds beats; off a read the data lines keep toggling, never stale
	assign mem_ready_o = mem_i.req && (!slow_i || tog_r);
	assign mem_rdata_o = mem_ready_o && !mem_i.we ? mem[mem_i.addr[7:0]] : {DATA_W{tog_r}};
	always @(posedge sys_clk_i) begin
		tog_r <= !tog_r;
		if (mem_ready_o && mem_i.we) mem[mem_i.addr[7:0]] <= mem_i.wdata;
	end
endmodule : mem_model
`default_nettype wire

//--- dma_channel_chk.sv
// checker: port assertions for the dma channel
`timescale 1ns/1ps
`default_nettype none
module dma_channel_chk
	import dma_pkg::*;
(
	// clock and control
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire channel_control_s ctrl_i,
	// memory side and status
	input wire mem_req_s mem_o,
	input wire logic mem_ready_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic end_irq_o,
	input wire logic [CNT_W-1:0] count_o
);
	// ====
	// properties
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_acc(bit w);
		mem_o.req && mem_o.we == w && mem_ready_i && ctrl_i.enable;
	endsequence
	a_irq_pulse: assert property (end_irq_o |=> !end_irq_o) else $error("irq long");
	a_irq_done: assert property (end_irq_o |-> done_o) else $error("irq no done");
	a_req_hold: assert property (mem_o.req && !mem_ready_i && ctrl_i.enable
		|=> mem_o.req && $stable(mem_o.addr)) else $error("beat dropped");
	a_count_step: assert property (s_acc(1) |=> count_o == $past(count_o) - CNT_ONE)
		else $error("count step");
	a_end_wrap: assert property (s_acc(1) |=> end_irq_o == ($past(count_o) == CNT_RESET))
		else $error("end timing");
	a_rd_wr: assert property (s_acc(0) |=> mem_o.req && mem_o.we) else $error("no write");
	a_sw_start: assert property ($rose(ctrl_i.software_start_bit) && ctrl_i.enable
		&& ctrl_i.trigger_sel == TRIG_SOFTWARE && !busy_o |-> ##2 mem_o.req && !mem_o.we)
		else $error("no start");
	a_abort: assert property (!ctrl_i.enable |=> !mem_o.req) else $error("no abort");
endmodule : dma_channel_chk
bind dma_channel dma_channel_chk u_dma_channel_chk (.*);
`default_nettype wire

//--- testbench.sv
// testbench: copy table, event pacing and refusals
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dma_pkg::*;
	typedef struct {int c; int s; int d; bit sm; bit dm; bit sl;} row_s;
	row_s rows [4] = '{'{0, 16, 64, 1, 1, 0}, '{3, 16, 80, 1, 1, 1},
		'{2, 32, 96, 0, 1, 0}, '{2, 32, 112, 1, 0, 1}};
	logic sys_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, slow = 1'b0;
	logic setup_load_i = 1'b0, done_clear_i = 1'b0, conversion_done_event_i = 1'b0;
	logic periph_a_event_i = 1'b0, periph_b_event_i = 1'b0;
	channel_control_s ctrl_i = '0;
	channel_setup_s setup_i = '0;
	mem_req_s mem_o;
	logic mem_ready_i, busy_o, done_o, end_irq_o;
	logic [DATA_W-1:0] mem_rdata_i;
	logic [CNT_W-1:0] count_o;
	int err_count = 0;
	int compares = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	dma_channel u_dma_channel (.*);
	mem_model u_mem_model (.sys_clk_i, .slow_i(slow), .mem_i(mem_o), .mem_ready_o(mem_ready_i),
		.mem_rdata_o(mem_rdata_i));
	// ====
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic arm(input row_s r, input logic [TRIG_W-1:0] t);
		ctrl_i = '0;
		setup_i = '{32'(r.s), 32'(r.d), 16'(r.c)};
		setup_load_i = 1'b1;
		@(negedge sys_clk_i);
		setup_load_i = 1'b0;
		slow = r.sl;
		ctrl_i = '{1'b1, t == TRIG_SOFTWARE, t, addr_mode_e'(r.sm), addr_mode_e'(r.dm)};
		@(negedge sys_clk_i);
		ctrl_i.software_start_bit = 1'b0;
	endtask : arm
	task automatic pulse;
		conversion_done_event_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		conversion_done_event_i = 1'b0;
		repeat (12) @(negedge sys_clk_i);
	endtask : pulse
	// ====
	// stimulus
	initial begin
		int a;
		int e;
		int i;
		repeat (3) @(negedge sys_clk_i);
		reset_i = 1'b0;
		chk({busy_o, done_o, end_irq_o, count_o}, 32'h0);
		foreach (rows[n]) begin
			arm(rows[n], TRIG_SOFTWARE);
			for (i = 0; i < 300 && done_o !== 1'b1; i++) @(negedge sys_clk_i);
			if (i == 300) err_count++;
			if (i == 300) end_sim();
			chk(count_o, 32'hFFFF);
			for (int k = 0; k <= rows[n].c; k++) begin
				a = rows[n].d + (rows[n].dm ? k : 0);
				e = 32'hA500 | (rows[n].s + (rows[n].sm ? k : 0));
				if (rows[n].dm || k == rows[n].c) chk(u_mem_model.mem[a], e);
			end
			$display("copy %0d ends", n);
		end
		arm('{1, 128, 144, 0, 1, 0}, TRIG_CONV_DONE);
		pulse();
		chk({done_o, count_o}, 32'h0);
		pulse();
		chk({done_o, count_o}, 32'h1FFFF);
		chk({u_mem_model.mem[144], u_mem_model.mem[145]}, 32'hA580A580);
		pulse();
		chk(count_o, 32'hFFFF);
		done_clear_i = 1'b1;
		@(negedge sys_clk_i);
		done_clear_i = 1'b0;
		chk(done_o, 32'h0);
		$display("event block ends");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
